// File: logic/oad_pkg.sv
package oad_pkg;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [1:0] OAD_MOD_NODISP = 2'h0;
  localparam logic [1:0] OAD_MOD_DISP8  = 2'h1;
  localparam logic [1:0] OAD_MOD_DISP16 = 2'h2;
  localparam logic [1:0] OAD_MOD_REG    = 2'h3;
  localparam logic [2:0] OAD_RM_DIRECT  = 3'h6;

  // Segment codes
  localparam logic [1:0] OAD_SEG_EXTRA  = 2'h0;
  localparam logic [1:0] OAD_SEG_CODE   = 2'h1;
  localparam logic [1:0] OAD_SEG_STACK  = 2'h2;
  localparam logic [1:0] OAD_SEG_DATA   = 2'h3;

  // Prefix pattern: top three and bottom three bits
  localparam logic [2:0] OAD_PFX_TOP    = 3'h1;
  localparam logic [2:0] OAD_PFX_BOT    = 3'h6;

  // Wait opcode
  localparam logic [7:0] OAD_OP_WAIT    = 8'h9B;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int OAD_CLK_NS          = 10;
  localparam int OAD_EA_CYCLES       = 4;
  localparam int OAD_WAIT_CYCLES     = 6;
  localparam int OAD_WORD_XFER_EXTRA = 4;

endpackage

// File: logic/oad_regfile.sv
`timescale 1ns/100ps
module oad_regfile
  import oad_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire logic [2:0]   wr_sel,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [2:0]   rd_sel,
  output logic      [W-1:0] rd_data,
  output logic      [W-1:0] base_reg,
  output logic      [W-1:0] base_pointer,
  output logic      [W-1:0] src_index,
  output logic      [W-1:0] dest_index
);

  // ----------------------------------------
  // Eight word registers, registered read port
  // ----------------------------------------
  logic [W-1:0] mem_r [8];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_sel] <= wr_data;
      end
      rd_data <= mem_r[rd_sel];
    end
  end

  assign base_reg     = mem_r[3];
  assign base_pointer = mem_r[5];
  assign src_index    = mem_r[6];
  assign dest_index   = mem_r[7];

endmodule

// File: logic/oad_decode.sv
`timescale 1ns/100ps
module oad_decode
  import oad_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         byte_valid,
  input  wire logic [7:0]   byte_in,
  input  wire logic         op_start,
  input  wire logic         word_op,
  input  wire logic         string_dst,
  input  wire logic         test_n,
  input  wire logic [1:0]   mem_xfers,
  input  wire logic         reg_wr_en,
  input  wire logic [2:0]   reg_wr_sel,
  input  wire logic [W-1:0] reg_wr_data,
  output logic              byte_ready,
  output logic              ea_valid,
  output logic [W-1:0]      effective_address,
  output logic [1:0]        seg_sel,
  output logic              is_reg,
  output logic [2:0]        reg_sel,
  output logic              reg_high_byte,
  output logic [W-1:0]      reg_value,
  output logic              wait_done,
  output logic [3:0]        word_extra_clks
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [6:0] {
    OAD_IDLE   = 7'h01,
    OAD_MODRM  = 7'h02,
    OAD_DLO    = 7'h04,
    OAD_DHI    = 7'h08,
    OAD_CALC   = 7'h10,
    OAD_WAITOP = 7'h20,
    OAD_DONE   = 7'h40
  } oad_state_t;

  typedef struct packed {
    oad_state_t  st;
    logic        ovr_vld;
    logic [1:0]  ovr_seg;
    logic [1:0]  mode;
    logic [2:0]  reg_f;
    logic [2:0]  rm;
    logic [15:0] disp;
    logic [2:0]  cnt;
    logic        ea_valid;
    logic [15:0] ea;
    logic [1:0]  seg;
    logic        is_reg;
    logic        wait_done;
  } oad_s_t;

  oad_s_t s_r;
  oad_s_t s_nxt;

  logic [W-1:0] bx_v;
  logic [W-1:0] bp_v;
  logic [W-1:0] si_v;
  logic [W-1:0] di_v;
  logic [W-1:0] rd_v;
  logic [W-1:0] base_v;
  logic         via_bp;
  logic         is_pfx;
  logic [1:0]   def_seg;
  logic [1:0]   seg_v;
  logic [2:0]   fld_v;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  oad_regfile #(.W(W)) u_rf (
    .core_clk     (core_clk),
    .rst          (rst),
    .wr_en        (reg_wr_en),
    .wr_sel       (reg_wr_sel),
    .wr_data      (reg_wr_data),
    .rd_sel       (s_r.rm),
    .rd_data      (rd_v),
    .base_reg     (bx_v),
    .base_pointer (bp_v),
    .src_index    (si_v),
    .dest_index   (di_v)
  );

  // ----------------------------------------
  // Address terms
  // ----------------------------------------
  assign is_pfx = (byte_in[7:5] == OAD_PFX_TOP) && (byte_in[2:0] == OAD_PFX_BOT);

  always_comb begin
    base_v = '0;
    via_bp = 1'b0;
    unique case (s_r.rm)
      3'h0: base_v = bx_v + si_v;
      3'h1: base_v = bx_v + di_v;
      3'h2: begin
        base_v = bp_v + si_v;
        via_bp = 1'b1;
      end
      3'h3: begin
        base_v = bp_v + di_v;
        via_bp = 1'b1;
      end
      3'h4: base_v = si_v;
      3'h5: base_v = di_v;
      3'h6: begin
        // Direct form drops the base pointer entirely
        if (s_r.mode == OAD_MOD_NODISP) begin
          base_v = '0;
        end else begin
          base_v = bp_v;
          via_bp = 1'b1;
        end
      end
      3'h7: base_v = bx_v;
    endcase
  end

  // Stack for base pointer, data otherwise
  assign def_seg = via_bp ? OAD_SEG_STACK : OAD_SEG_DATA;

  // ----------------------------------------
  // Segment choice
  // ----------------------------------------
  // String destination wins over any prefix
  always_comb begin
    seg_v = def_seg;
    if (string_dst) begin
      seg_v = OAD_SEG_EXTRA;
    end else if (s_r.ovr_vld) begin
      seg_v = s_r.ovr_seg;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.wait_done = 1'b0;
    unique case (s_r.st)
      OAD_IDLE: begin
        if (byte_valid && is_pfx) begin
          s_nxt.ovr_vld = 1'b1;
          s_nxt.ovr_seg = byte_in[4:3];
        end else if (byte_valid && byte_in == OAD_OP_WAIT) begin
          s_nxt.st  = OAD_WAITOP;
          s_nxt.cnt = 3'h0;
        end else if (byte_valid && op_start) begin
          s_nxt.st       = OAD_MODRM;
          s_nxt.ea_valid = 1'b0;
        end
      end
      OAD_MODRM: begin
        // Second byte: mode, reg, r/m; displacement follows it
        if (byte_valid) begin
          s_nxt.mode  = byte_in[7:6];
          s_nxt.reg_f = byte_in[5:3];
          s_nxt.rm    = byte_in[2:0];
          s_nxt.disp  = '0;
          s_nxt.cnt   = 3'h0;
          if (byte_in[7:6] == OAD_MOD_REG) begin
            s_nxt.st = OAD_DONE;
          end else if (byte_in[7:6] == OAD_MOD_NODISP && byte_in[2:0] != OAD_RM_DIRECT) begin
            s_nxt.st = OAD_CALC;
          end else begin
            s_nxt.st = OAD_DLO;
          end
        end
      end
      OAD_DLO: begin
        if (byte_valid) begin
          if (s_r.mode == OAD_MOD_DISP8) begin
            s_nxt.disp = {{8{byte_in[7]}}, byte_in};
            s_nxt.st   = OAD_CALC;
          end else begin
            s_nxt.disp = {8'h00, byte_in};
            s_nxt.st   = OAD_DHI;
          end
        end
      end
      OAD_DHI: begin
        if (byte_valid) begin
          s_nxt.disp = {byte_in, s_r.disp[7:0]};
          s_nxt.st   = OAD_CALC;
        end
      end
      OAD_CALC: begin
        // Fixed latency keeps timing the same for modes 00-10; mode 11 never enters this state
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt == 3'(OAD_EA_CYCLES - 1)) begin
          s_nxt.ea  = base_v + s_r.disp;
          s_nxt.seg = seg_v;
          s_nxt.is_reg   = 1'b0;
          s_nxt.ea_valid = 1'b1;
          s_nxt.ovr_vld  = 1'b0;
          s_nxt.st       = OAD_IDLE;
        end
      end
      OAD_WAITOP: begin
        // Stall holds while test input stays high
        if (s_r.cnt == 3'(OAD_WAIT_CYCLES - 1)) begin
          if (!test_n) begin
            s_nxt.wait_done = 1'b1;
            s_nxt.st        = OAD_IDLE;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
      end
      OAD_DONE: begin
        s_nxt.is_reg   = 1'b1;
        s_nxt.ea_valid = 1'b1;
        s_nxt.ovr_vld  = 1'b0;
        s_nxt.st       = OAD_IDLE;
      end
      default: s_nxt.st = OAD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: OAD_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Stream handshake
  // ----------------------------------------
  // Only the byte-collecting states take from the stream
  always_comb begin
    unique case (s_r.st)
      OAD_IDLE, OAD_MODRM, OAD_DLO, OAD_DHI: byte_ready = 1'b1;
      default:                               byte_ready = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Register operand field
  // ----------------------------------------
  // Mode 11 names its register in r/m; otherwise the reg field does
  always_comb begin
    if (s_r.mode == OAD_MOD_REG) begin
      fld_v = s_r.rm;
    end else begin
      fld_v = s_r.reg_f;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ea_valid          = s_r.ea_valid;
  assign effective_address = s_r.ea;
  assign seg_sel           = s_r.seg;
  assign is_reg            = s_r.is_reg;
  assign wait_done         = s_r.wait_done;
  assign reg_value         = rd_v;

  // Byte selects wrap: low halves 0-3, high halves 4-7
  always_comb begin
    if (word_op) begin
      reg_sel       = fld_v;
      reg_high_byte = 1'b0;
    end else begin
      reg_sel       = {1'b0, fld_v[1:0]};
      reg_high_byte = fld_v[2];
    end
  end

  // Byte transfers add nothing; time is per memory transfer
  always_comb begin
    if (word_op) begin
      word_extra_clks = 4'(OAD_WORD_XFER_EXTRA * mem_xfers);
    end else begin
      word_extra_clks = 4'h0;
    end
  end

endmodule

// File: dv/oad_decode_properties.sv
`timescale 1ns/100ps
module oad_decode_properties
  import oad_pkg::*;
#(
  parameter int W = 16
) (
  input logic         core_clk,
  input logic         rst,
  input logic         byte_valid,
  input logic         op_start,
  input logic         word_op,
  input logic         string_dst,
  input logic         test_n,
  input logic [1:0]   mem_xfers,
  input logic         byte_ready,
  input logic         ea_valid,
  input logic [W-1:0] effective_address,
  input logic [1:0]   seg_sel,
  input logic         is_reg,
  input logic [2:0]   reg_sel,
  input logic         reg_high_byte,
  input logic         wait_done,
  input logic [3:0]   word_extra_clks
);
  // ----
  // Checks
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_XTRA: assert property (word_extra_clks == (word_op ? {mem_xfers, 2'h0} : 4'h0))
    else $error("extra clocks wrong");
  AST_REG_LAT: assert property ($rose(ea_valid) && is_reg |-> $past(byte_valid && byte_ready, 2))
    else $error("register result late");
  AST_EA_LAT: assert property ($rose(ea_valid) && !is_reg |->
    $past(byte_valid && byte_ready, 5) && !$past(byte_ready))
    else $error("address result not four clocks");
  AST_STAND: assert property (ea_valid && !(byte_valid && op_start) |=>
    $stable(effective_address) && $stable(seg_sel))
    else $error("address result moved");
  AST_STR: assert property ($rose(ea_valid) && !is_reg && $past(string_dst) |->
    seg_sel == OAD_SEG_EXTRA)
    else $error("string destination segment");
  AST_BYTE_REG: assert property ($rose(ea_valid) && is_reg && !word_op |-> !reg_sel[2])
    else $error("byte register index");
  AST_WORD_REG: assert property ($rose(ea_valid) && is_reg && word_op |-> !reg_high_byte)
    else $error("word op picked high byte");
  AST_WAIT_ONE: assert property (wait_done |=> !wait_done)
    else $error("wait pulse too long");
  AST_WAIT_TST: assert property (wait_done |-> !$past(test_n))
    else $error("wait ended with test high");
  cover property (wait_done);
  cover property ($rose(ea_valid) && is_reg);
  cover property (ea_valid && seg_sel == OAD_SEG_STACK);
endmodule
bind oad_decode oad_decode_properties #(.W(W)) u_props (.core_clk, .rst, .byte_valid, .op_start,
  .word_op, .string_dst, .test_n, .mem_xfers, .byte_ready, .ea_valid, .effective_address,
  .seg_sel, .is_reg, .reg_sel, .reg_high_byte, .wait_done, .word_extra_clks);

// File: dv/oad_decode_test.sv
`timescale 1ns/100ps
module oad_decode_test
  import oad_pkg::*;
;
  // ----
  // Bench
  // ----
  logic        core_clk, rst, byte_valid, op_start, word_op, string_dst, test_n, reg_wr_en;
  logic [7:0]  byte_in;
  logic [1:0]  mem_xfers, seg_sel;
  logic [2:0]  reg_wr_sel, reg_sel;
  logic [15:0] reg_wr_data, effective_address, reg_value;
  logic        byte_ready, ea_valid, is_reg, reg_high_byte, wait_done;
  logic [3:0]  word_extra_clks;
  int          n_fail = 0, checks_done = 0, cyc = 0;

  oad_decode #(.W(16)) u_dut (.core_clk, .rst, .byte_valid, .byte_in, .op_start, .word_op,
    .string_dst, .test_n, .mem_xfers, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .byte_ready,
    .ea_valid, .effective_address, .seg_sel, .is_reg, .reg_sel, .reg_high_byte, .reg_value,
    .wait_done, .word_extra_clks);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end

  // Byte stays up until taken; caller drops it, so no double drive
  task send(input logic [7:0] b, input logic s);
    @(negedge core_clk);
    byte_in = b;
    op_start = s;
    byte_valid = 1'b1;
    #1;
    while (byte_ready !== 1'b1) begin
      @(negedge core_clk);
      #1;
    end
    @(posedge core_clk);
  endtask

  task wr(input logic [2:0] s, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_wr_sel = s;
    reg_wr_data = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask

  task result;
    @(negedge core_clk);
    byte_valid = 1'b0;
    op_start = 1'b0;
    repeat (12) if (ea_valid !== 1'b1) @(negedge core_clk);
  endtask

  function logic [15:0] ea_of(input logic [1:0] md, input logic [2:0] rm);
    logic [15:0] d, b;
    d = md == 2'h2 ? 16'h1284 : (md == 2'h1 ? 16'hFF84 : 16'h0000);
    case (rm)
      3'h0: b = 16'h1300;
      3'h1: b = 16'h1040;
      3'h2: b = 16'h2300;
      3'h3: b = 16'h2040;
      3'h4: b = 16'h0300;
      3'h5: b = 16'h0040;
      3'h6: b = md == 2'h0 ? 16'h1284 : 16'h2000;
      default: b = 16'h1000;
    endcase
    return b + d;
  endfunction

  task op(input logic [1:0] md, input logic [2:0] rm, input logic [1:0] sg);
    send(8'h8B, 1'b1);
    send({md, 3'h2, rm}, 1'b0);
    if (md == 2'h1 || md == 2'h2 || (md == 2'h0 && rm == 3'h6))
      send(8'h84, 1'b0);
    if (md == 2'h2 || (md == 2'h0 && rm == 3'h6))
      send(8'h12, 1'b0);
    result();
    if (md == 2'h3) begin
      check(16'(is_reg), 16'h0001);
      check(16'(ea_valid), 16'h0001);
    end else begin
      check(effective_address, ea_of(md, rm));
      check(16'(seg_sel), 16'(sg));
    end
  endtask

  task t_modes;
    for (int m = 0; m < 3; m++)
      for (int r = 0; r < 8; r++)
        op(2'(m), 3'(r), (r == 2 || r == 3 || (r == 6 && m != 0)) ? OAD_SEG_STACK : OAD_SEG_DATA);
  endtask

  task t_override;
    for (int s = 0; s < 4; s++) begin
      send({3'h1, 2'(s), 3'h6}, 1'b0);
      op(2'h1, 3'h4, 2'(s));
    end
    string_dst = 1'b1;
    send({3'h1, OAD_SEG_DATA, 3'h6}, 1'b0);
    op(2'h1, 3'h5, OAD_SEG_EXTRA);
    string_dst = 1'b0;
  endtask

  task t_reg;
    word_op = 1'b1;
    op(2'h3, 3'h3, 2'h0);
    check(16'(is_reg), 16'h0001);
    check(reg_value, 16'h1000);
    word_op = 1'b0;
    op(2'h3, 3'h7, 2'h0);
    check(16'({reg_sel, reg_high_byte}), 16'h0007);
  endtask

  task t_wait;
    int n;
    for (int t = 1; t >= 0; t--) begin
      test_n = 1'(t);
      send(OAD_OP_WAIT, 1'b0);
      n = 0;
      while (wait_done !== 1'b1 && n < 20) begin
        @(negedge core_clk);
        byte_valid = 1'b0;
        n++;
        if (n == 14 && t == 1) begin
          check(16'(wait_done), 16'h0000);
          test_n = 1'b0;
        end
      end
      // Pulse is seen half a cycle after the edge that ends the wait
      if (t == 0)
        check(16'(n - 1), 16'(OAD_WAIT_CYCLES));
    end
  endtask

  task t_extra;
    for (int k = 0; k < 8; k++) begin
      @(negedge core_clk);
      word_op = k[2];
      mem_xfers = 2'(k);
      #1;
      check(16'(word_extra_clks), k[2] ? 16'(4 * (k % 4)) : 16'h0000);
    end
  endtask

  initial begin
    {rst, test_n} = 2'h3;
    {byte_valid, op_start, word_op, string_dst, reg_wr_en} = 5'h00;
    {byte_in, mem_xfers, reg_wr_sel, reg_wr_data} = 29'h0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    wr(3'h3, 16'h1000);
    wr(3'h5, 16'h2000);
    wr(3'h6, 16'h0300);
    wr(3'h7, 16'h0040);
    t_modes();
    t_override();
    t_reg();
    t_wait();
    t_extra();
    close_out();
  end
endmodule
